// ==== lrcr_pkg.sv ====
// Package for the legacy resource configuration register bank.
// Assumes an AXI4-Lite master on the same 10 MHz clock.
package lrcr_pkg;

  // ----------------------------------------------------------------
  // Register indexes and byte addresses
  // ----------------------------------------------------------------
  localparam logic [7:0]  IDX_PAR_BASE   = 8'h23;
  localparam logic [7:0]  IDX_SER1_BASE  = 8'h24;
  localparam logic [7:0]  IDX_SER2_BASE  = 8'h25;
  localparam logic [7:0]  IDX_DMA_SEL    = 8'h26;
  localparam logic [7:0]  IDX_ECP_IND    = 8'h22;
  localparam logic [11:0] ADDR_INDEX     = 12'h000;
  localparam logic [11:0] ADDR_DATA      = 12'h004;
  localparam logic [11:0] ADDR_CTRL      = 12'h008;
  localparam logic [11:0] ADDR_ECP_IND   = 12'h00c;

  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_BASE     = 8'h00;
  localparam logic [7:0] RST_DMA_SEL  = 8'hff;
  localparam logic [7:0] RST_ECP_IND  = 8'h00;
  localparam logic [7:0] ECP_IND_MASK = 8'h3f;
  localparam logic [7:0] SER_MASK     = 8'hfe;
  localparam logic [3:0] DMA_NONE     = 4'hf;
  localparam logic [3:0] DMA_LAST     = 4'h3;
  localparam int         NUM_DMA      = 4;

  // Control register bits
  localparam int CTL_CFG  = 0;
  localparam int CTL_EPP  = 1;
  localparam int CTL_ECP  = 2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [11:0] awaddr;
    logic        awvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        bready;
    logic [11:0] araddr;
    logic        arvalid;
    logic        rready;
  } lrcr_axi_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } lrcr_axi_rsp_t;

  typedef struct packed {
    logic [NUM_DMA-1:0] drq_out;
    logic [NUM_DMA-1:0] drq_oe;
    logic               par_sel;
    logic               ser1_sel;
    logic               ser2_sel;
  } lrcr_port_t;

endpackage

// ==== lrcr_regs.sv ====
// Legacy resource configuration registers: port base decoders, DMA
// routing and the ECP software indicator, reached over AXI4-Lite.
// Assumes host I/O address, DMA requests and modes are synchronous.
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ns
module lrcr_regs
  import lrcr_pkg::*;
(
  input  wire logic               ref_clk,      // 10 MHz clock
  input  wire logic               resetn,       // Power-on reset, low
  input  wire logic               hard_resetn,  // Hard reset, low, sync
  input  wire lrcr_pkg::lrcr_axi_req_t axi_req, // AXI4-Lite requests
  output lrcr_pkg::lrcr_axi_rsp_t      axi_rsp, // AXI4-Lite responses
  input  wire logic [15:0]        host_addr,    // Host I/O address
  input  wire logic               par_drq,      // Parallel DMA request
  input  wire logic               flp_drq,      // Floppy DMA request
  output lrcr_pkg::lrcr_port_t         port_out      // Selects and DRQs
);
  import lrcr_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    lrcr_axi_rsp_t rsp;
    logic          aw_got;
    logic          w_got;
    logic [11:0]   awaddr;
    logic [31:0]   wdata;
    logic [3:0]    wstrb;
    logic [7:0]    index;
    logic [2:0]    ctrl;
    logic [7:0]    par_base;
    logic [7:0]    ser1_base;
    logic [7:0]    ser2_base;
    logic [7:0]    dma_sel;
    logic [7:0]    ecp_ind;
    lrcr_port_t    port;
  } lrcr_state_t;

  lrcr_state_t s_q;
  lrcr_state_t s_d;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Serial decode: upper zero, A2:0 ignored, off when bits 9,8 zero
  function automatic logic ser_hit(input logic [15:0] a,
                                   input logic [7:0]  b);
    ser_hit = (a[15:10] == 6'h00) && (b[7:6] != 2'h0)
              && (a[9:3] == b[7:1]);
  endfunction

  // Indexed register read
  function automatic logic [7:0] cfg_rd(input lrcr_state_t s);
    cfg_rd = 8'h00;
    if (s.ctrl[CTL_CFG]) begin
      case (s.index)
        IDX_PAR_BASE:  cfg_rd = s.par_base;
        IDX_SER1_BASE: cfg_rd = s.ser1_base & SER_MASK;
        IDX_SER2_BASE: cfg_rd = s.ser2_base & SER_MASK;
        IDX_DMA_SEL:   cfg_rd = s.dma_sel;
        default:       cfg_rd = 8'h00;
      endcase
    end
  endfunction

  // Byte-lane merge for lane zero
  function automatic logic [7:0] lane0(input logic [7:0]  old,
                                       input logic [31:0] d,
                                       input logic [3:0]  st);
    lane0 = st[0] ? d[7:0] : old;
  endfunction

  // DMA code to channel one-hot; reserved and none give zero
  function automatic logic [NUM_DMA-1:0] dma_dec(input logic [3:0] c);
    dma_dec = '0;
    if (c <= DMA_LAST)
      dma_dec[c[1:0]] = 1'b1;
  endfunction

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  logic               wr_fire;
  logic [7:0]         wbyte;
  logic [NUM_DMA-1:0] par_ch;
  logic [NUM_DMA-1:0] flp_ch;
  logic               par_up;
  logic               par_lo;

  always_comb begin
    s_d     = s_q;
    wr_fire = 1'b0;
    wbyte   = 8'h00;
    par_ch  = '0;
    flp_ch  = '0;
    par_up  = 1'b0;
    par_lo  = 1'b0;

    // Write address and data taken in either order
    if (s_q.rsp.awready && axi_req.awvalid) begin
      s_d.aw_got      = 1'b1;
      s_d.awaddr      = axi_req.awaddr;
      s_d.rsp.awready = 1'b0;
    end
    if (s_q.rsp.wready && axi_req.wvalid) begin
      s_d.w_got      = 1'b1;
      s_d.wdata      = axi_req.wdata;
      s_d.wstrb      = axi_req.wstrb;
      s_d.rsp.wready = 1'b0;
    end

    if (s_q.aw_got && s_q.w_got && !s_q.rsp.bvalid) begin
      wr_fire       = 1'b1;
      wbyte         = lane0(8'h00, s_q.wdata, s_q.wstrb);
      s_d.aw_got    = 1'b0;
      s_d.w_got     = 1'b0;
      s_d.rsp.bvalid = 1'b1;
      s_d.rsp.bresp  = RESP_OKAY;
      case (s_q.awaddr)
        ADDR_INDEX: s_d.index = lane0(s_q.index, s_q.wdata, s_q.wstrb);
        ADDR_CTRL: begin
          if (s_q.wstrb[0])
            s_d.ctrl = s_q.wdata[2:0];
        end
        ADDR_ECP_IND: begin
          if (s_q.wstrb[0])
            s_d.ecp_ind = wbyte & ECP_IND_MASK;
        end
        ADDR_DATA: begin
          if (s_q.ctrl[CTL_CFG] && s_q.wstrb[0]) begin
            case (s_q.index)
              IDX_PAR_BASE:  s_d.par_base  = wbyte;
              IDX_SER1_BASE: s_d.ser1_base = wbyte & SER_MASK;
              IDX_SER2_BASE: s_d.ser2_base = wbyte & SER_MASK;
              IDX_DMA_SEL:   s_d.dma_sel   = wbyte;
              default:       s_d.dma_sel   = s_q.dma_sel;
            endcase
          end
        end
        default: s_d.rsp.bresp = RESP_SLVERR;
      endcase
    end
    if (s_q.rsp.bvalid && axi_req.bready) begin
      s_d.rsp.bvalid  = 1'b0;
      s_d.rsp.awready = 1'b1;
      s_d.rsp.wready  = 1'b1;
    end

    // Read channel
    if (s_q.rsp.arready && axi_req.arvalid) begin
      s_d.rsp.arready = 1'b0;
      s_d.rsp.rvalid  = 1'b1;
      s_d.rsp.rresp   = RESP_OKAY;
      s_d.rsp.rdata   = 32'h0000_0000;
      case (axi_req.araddr)
        ADDR_INDEX:   s_d.rsp.rdata[7:0] = s_q.index;
        ADDR_DATA:    s_d.rsp.rdata[7:0] = cfg_rd(s_q);
        ADDR_CTRL:    s_d.rsp.rdata[2:0] = s_q.ctrl;
        ADDR_ECP_IND: s_d.rsp.rdata[7:0] = s_q.ecp_ind & ECP_IND_MASK;
        default:      s_d.rsp.rresp      = RESP_SLVERR;
      endcase
    end
    if (s_q.rsp.rvalid && axi_req.rready) begin
      s_d.rsp.rvalid  = 1'b0;
      s_d.rsp.arready = 1'b1;
    end

    // Hard reset clears only the ECP indicator
    if (!hard_resetn)
      s_d.ecp_ind = RST_ECP_IND;

    // Parallel port decode
    par_up = s_q.ctrl[CTL_ECP] ? (host_addr[15:11] == 5'h00)
                               : (host_addr[15:10] == 6'h00);
    if (s_q.ctrl[CTL_EPP])
      par_lo = host_addr[9:3] == s_q.par_base[7:1];
    else
      par_lo = host_addr[9:2] == s_q.par_base;
    s_d.port.par_sel = par_up && par_lo
                       && (s_q.par_base[7:6] != 2'h0);
    s_d.port.ser1_sel = ser_hit(host_addr, s_q.ser1_base);
    s_d.port.ser2_sel = ser_hit(host_addr, s_q.ser2_base);

    // DMA routing from hardware select fields only
    par_ch = dma_dec(s_q.dma_sel[3:0]);
    flp_ch = dma_dec(s_q.dma_sel[7:4]);
    s_d.port.drq_oe  = par_ch | flp_ch;
    s_d.port.drq_out = (par_ch & {NUM_DMA{par_drq}})
                       | (flp_ch & {NUM_DMA{flp_drq}});
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      s_q             <= '0;
      s_q.rsp.awready <= 1'b1;
      s_q.rsp.wready  <= 1'b1;
      s_q.rsp.arready <= 1'b1;
      s_q.par_base    <= RST_BASE;
      s_q.ser1_base   <= RST_BASE;
      s_q.ser2_base   <= RST_BASE;
      s_q.dma_sel     <= RST_DMA_SEL;
      s_q.ecp_ind     <= RST_ECP_IND;
    end else begin
      s_q <= s_d;
    end
  end

  assign axi_rsp  = s_q.rsp;
  assign port_out = s_q.port;

endmodule

// ==== lrcr_regs_bench.sv ====
// Self-checking bench for the legacy resource register bank.
// Assumes lrcr_regs with its checker bound; bench is bus master.
`timescale 1ns/1ns
module lrcr_regs_bench;
  import lrcr_pkg::*;
  logic          ref_clk     = 1'b0;
  logic          resetn      = 1'b0;
  logic          hard_resetn = 1'b1;
  logic          par_drq     = 1'b0;
  logic          flp_drq     = 1'b0;
  logic [15:0]   host_addr   = 16'h0000;
  lrcr_axi_req_t req         = '0;
  lrcr_axi_rsp_t rsp;
  lrcr_port_t    po;
  int            n_mismatch  = 0;
  int            checked     = 0;
  int            cyc         = 0;
  logic [7:0]    rd;
  logic [1:0]    rs;

  always #50 ref_clk = ~ref_clk;

  lrcr_regs u_lrcr_regs (.ref_clk(ref_clk), .resetn(resetn),
    .hard_resetn(hard_resetn), .axi_req(req), .axi_rsp(rsp),
    .host_addr(host_addr), .par_drq(par_drq), .flp_drq(flp_drq),
    .port_out(po));

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic stop_test;
    $display("mismatches %0d checks %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d,
                    input logic [1:0] er);
    int n;
    n = 0;
    req.awaddr  <= a;
    req.awvalid <= 1'b1;
    req.wdata   <= {24'h000000, d};
    req.wstrb   <= 4'hf;
    req.wvalid  <= 1'b1;
    req.bready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (rsp.awready) req.awvalid <= 1'b0;
      if (rsp.wready) req.wvalid <= 1'b0;
    end while (rsp.bvalid !== 1'b1 && n < 40);
    req.bready <= 1'b0;
    if (n >= 40) n_mismatch++;
    chk({6'h00, rsp.bresp}, {6'h00, er});
    @(posedge ref_clk);
  endtask

  task automatic rd_reg(input logic [11:0] a, output logic [7:0] d,
                        output logic [1:0] r);
    int n;
    n = 0;
    req.araddr  <= a;
    req.arvalid <= 1'b1;
    req.rready  <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (rsp.arready) req.arvalid <= 1'b0;
    end while (rsp.rvalid !== 1'b1 && n < 40);
    req.rready <= 1'b0;
    d = rsp.rdata[7:0];
    r = rsp.rresp;
    if (n >= 40) n_mismatch++;
    @(posedge ref_clk);
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
    logic [7:0] d;
    logic [1:0] r;
    rd_reg(a, d, r);
    chk(d, exp);
  endtask

  task automatic ix_wr(input logic [7:0] ix, input logic [7:0] d);
    wr(ADDR_INDEX, ix, RESP_OKAY);
    wr(ADDR_DATA, d, RESP_OKAY);
  endtask

  task automatic ix_rd(input logic [7:0] ix, input logic [7:0] exp);
    wr(ADDR_INDEX, ix, RESP_OKAY);
    rd_chk(ADDR_DATA, exp);
  endtask

  task automatic dec(input logic [15:0] a, input logic [2:0] exp);
    host_addr <= a;
    repeat (3) @(posedge ref_clk);
    chk({5'h00, po.par_sel, po.ser1_sel, po.ser2_sel}, {5'h00, exp});
  endtask

  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // Sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    rd_chk(ADDR_ECP_IND, 8'h00);
    ix_wr(IDX_PAR_BASE, 8'h5a);
    wr(ADDR_CTRL, 8'h01, RESP_OKAY);
    for (int i = 0; i < 4; i++) begin
      ix_rd(IDX_PAR_BASE + i[7:0], (i == 3) ? 8'hff : 8'h00);
    end
    wr(ADDR_ECP_IND, 8'hff, RESP_OKAY);
    rd_chk(ADDR_ECP_IND, 8'h3f);
    chk({4'h0, po.drq_oe}, 8'h00);
    hard_resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    hard_resetn <= 1'b1;
    rd_chk(ADDR_ECP_IND, 8'h00);
    for (int k = 0; k < 2; k++) begin
      ix_wr(IDX_SER1_BASE + k[7:0], 8'hfe);
      ix_rd(IDX_SER1_BASE + k[7:0], 8'hfe);
      dec(16'h03fd, (k == 0) ? 3'b010 : 3'b001);
      dec(16'h07f8, 3'b000);
      ix_wr(IDX_SER1_BASE + k[7:0], 8'h00);
      dec(16'h0000, 3'b000);
    end
    ix_wr(IDX_PAR_BASE, 8'hfe);
    ix_rd(IDX_PAR_BASE, 8'hfe);
    dec(16'h03fb, 3'b100);
    dec(16'h03fc, 3'b000);
    dec(16'h07f8, 3'b000);
    wr(ADDR_CTRL, 8'h03, RESP_OKAY);
    dec(16'h03fc, 3'b100);
    wr(ADDR_CTRL, 8'h05, RESP_OKAY);
    dec(16'h07f8, 3'b100);
    ix_wr(IDX_PAR_BASE, 8'h00);
    dec(16'h0000, 3'b000);
    par_drq <= 1'b1;
    for (int c = 0; c < 4; c++) begin
      ix_wr(IDX_DMA_SEL, {4'hf, c[3:0]});
      repeat (2) @(posedge ref_clk);
      chk({po.drq_oe, po.drq_out & po.drq_oe}, {2{4'h1 << c}});
    end
    ix_wr(IDX_DMA_SEL, 8'h20);
    par_drq <= 1'b0;
    flp_drq <= 1'b1;
    repeat (2) @(posedge ref_clk);
    chk({po.drq_oe, po.drq_out & po.drq_oe}, 8'h54);
    wr(12'h010, 8'h11, RESP_SLVERR);
    rd_reg(12'h010, rd, rs);
    chk(rd, 8'h00);
    chk({6'h00, rs}, {6'h00, RESP_SLVERR});
    stop_test();
  end
endmodule

// ==== lrcr_regs_chk.sv ====
// Port checker for the legacy resource register bank.
// Assumes it is bound to lrcr_regs and sees only its ports.
`timescale 1ns/1ns
module lrcr_regs_chk
  import lrcr_pkg::*;
(
  input wire logic               ref_clk,     // Clock
  input wire logic               resetn,      // Power-on reset, low
  input wire logic               hard_resetn, // Hard reset, low
  input wire lrcr_pkg::lrcr_axi_req_t axi_req, // Bus requests
  input wire lrcr_pkg::lrcr_axi_rsp_t axi_rsp, // Bus responses
  input wire logic [15:0]        host_addr,   // Host address
  input wire logic               par_drq,     // Parallel request
  input wire logic               flp_drq,     // Floppy request
  input wire lrcr_pkg::lrcr_port_t    port_out     // Selects and requests
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence s_wr_take;
    axi_req.awvalid && axi_rsp.awready && axi_req.wvalid && axi_rsp.wready;
  endsequence
  sequence s_rd_take;
    axi_req.arvalid && axi_rsp.arready;
  endsequence
  AST_WR_RESP: assert property (s_wr_take |-> ##[1:2] axi_rsp.bvalid)
    else $error("write response missing");
  AST_RD_RESP: assert property (s_rd_take |-> ##[1:2] axi_rsp.rvalid)
    else $error("read response missing");
  AST_R_HOLD: assert property (axi_rsp.rvalid && !axi_req.rready
    |=> axi_rsp.rvalid && $stable(axi_rsp.rdata))
    else $error("read data dropped");
  AST_RD_BYTE: assert property (axi_rsp.rvalid
    |-> axi_rsp.rdata[31:8] == 24'h000000)
    else $error("read upper bits set");
  AST_SER1_UP: assert property (port_out.ser1_sel
    |-> $past(host_addr[15:10]) == 6'h00 && $past(host_addr[9:8]) != 2'h0)
    else $error("serial one select bad");
  AST_SER2_UP: assert property (port_out.ser2_sel
    |-> $past(host_addr[15:10]) == 6'h00 && $past(host_addr[9:8]) != 2'h0)
    else $error("serial two select bad");
  AST_PAR_UP: assert property (port_out.par_sel
    |-> $past(host_addr[15:11]) == 5'h00 && $past(host_addr[9:8]) != 2'h0)
    else $error("parallel select bad");
  AST_DRQ_OE: assert property ($countones(port_out.drq_oe) <= 2
    && (port_out.drq_out & ~port_out.drq_oe) == 4'h0)
    else $error("too many requests driven");
endmodule

bind lrcr_regs lrcr_regs_chk u_lrcr_regs_chk (.ref_clk(ref_clk),
  .resetn(resetn), .hard_resetn(hard_resetn), .axi_req(axi_req),
  .axi_rsp(axi_rsp), .host_addr(host_addr), .par_drq(par_drq),
  .flp_drq(flp_drq), .port_out(port_out));
